// ===== verilog/trace_cmp_params.svh
// Offsets, field positions, reset values and timing for the trace comparator
// Assumes a 32-bit Wishbone slave with byte addresses
`ifndef TRACE_CMP_PARAMS_SVH
`define TRACE_CMP_PARAMS_SVH

`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_TRACE_INDEX 8'h08
`define OFF_TRACE_DATA 8'h0C
`define OFF_MAG_BASE 8'h10
`define OFF_BIT_BASE 8'h20
`define OFF_FILE_MASK 8'hF0

`define CTRL_QUAL_LSB 0
`define CTRL_EVENT_LIMIT_COMMAND_BIT 4
`define CTRL_BRK_LIM_BIT 5
`define CTRL_WIDE_BIT 6
`define CTRL_RESET 7'h00

`define MAG_MODE_LSB 16
`define BIT_CARE_LSB 8
`define STAT_SEL_BIT 4
`define STAT_COUNT_LSB 16

`define CLK_MHZ 250
`define T_CLOCK0_NS 60
`define T_FILE1_NS 100
`define T_CLOCK1_NS 160

`define STORE_DEPTH 256
`define ENTRY_W 24

`endif

// ===== verilog/trace_cmp_pkg.sv
// Types shared by the trace comparator and its store
// Assumes trace_cmp_params.svh supplies the numeric constants
package trace_cmp_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FIRST = 2'b01,
    SEQ_SECOND = 2'b10
  } seq_state_t;

  typedef enum logic [3:0] {
    QUAL_ALL = 4'h0,
    QUAL_FETCH = 4'h1,
    QUAL_IO = 4'h2,
    QUAL_MEM = 4'h3,
    QUAL_READ = 4'h4,
    QUAL_WRITE = 4'h5,
    QUAL_IO_READ = 4'h6,
    QUAL_IO_WRITE = 4'h7,
    QUAL_MEM_READ = 4'h8,
    QUAL_MEM_WRITE = 4'h9
  } qualifier_t;

  typedef enum logic [2:0] {
    MAG_NONE = 3'h0,
    MAG_GE = 3'h1,
    MAG_EQ = 3'h2,
    MAG_LE = 3'h3,
    MAG_EQ8 = 3'h4
  } mag_mode_t;
endpackage

// ===== verilog/trace_mem_if.sv
// Carrier between the comparator and its trace store memory
// Assumes one clock shared by both ends
interface trace_mem_if;
  logic storeStrobeN;
  logic [7:0] wrAddr;
  logic [23:0] wrData;
  logic [7:0] rdAddr;
  logic [23:0] rdData;
  modport writer (output storeStrobeN, output wrAddr, output wrData, output rdAddr,
    input rdData);
  modport mem (input storeStrobeN, input wrAddr, input wrData, input rdAddr,
    output rdData);
endinterface

// ===== verilog/trace_store_mem.sv
// 256 x 24 trace store with registered read data
// Assumes writer gives a one-cycle low store strobe per entry
`include "trace_cmp_params.svh"
module trace_store_mem
  import trace_cmp_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic reset, // Async reset, active high
  trace_mem_if.mem port // Store access
);
  logic [`ENTRY_W-1:0] cells [`STORE_DEPTH];
  logic lastStrobeN;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lastStrobeN <= 1'b1;
    end else begin
      lastStrobeN <= port.storeStrobeN;
    end
  end

  // Latch on falling store strobe
  always_ff @(posedge ref_clk) begin
    if (lastStrobeN && !port.storeStrobeN) begin
      cells[port.wrAddr] <= port.wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    port.rdData <= cells[port.rdAddr];
  end
endmodule // trace_store_mem

// ===== verilog/bus_trace_event_comparator.sv
// Bus trace capture and two-event comparator with Wishbone registers
// Assumes bus pins are asynchronous and stable around strobe edges
//
// Operation
// - Full store overwrites oldest transaction
// - Readout runs oldest to newest
// - Select low: address side; high: data side
// - Store latches on store strobe fall
// - Magnitude compare: ge, eq, le, 8-bit eq
// - Bitwise match of probe or bus-op bits
// - Leading edge captures address and bus-op
// - File 00 result into first address result
// - File 01 at 100 ns into R1
// - Trailing edge captures data and probe
// - File 10 result into first data result
// - File 11 at 100 ns into R3
// - Steps at 60, 100, 160 ns
// - Comparator high on match, low otherwise
// - Unprogrammed file always matches
// - Both comparator outputs ANDed per file
// - R0 and R2 fire first event
// - R1 and R3 fire second event
// - Either limit command raises limit qualifier
// - Limit also requires R1 for first event
// - Store only qualifier-passing transactions
// - Store holds 256 entries of 24 bits
`include "trace_cmp_params.svh"
module bus_trace_event_comparator
  import trace_cmp_pkg::*;
(
  input wire logic ref_clk, // 250 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [31:0] dat_i, // Write data
  input wire logic [3:0] sel_i, // Byte enables
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  input wire logic transaction_strobe, // Bus transaction strobe
  input wire logic [15:0] busAddr, // Address bus
  input wire logic [2:0] busOp, // {fetch, readWrite, memIo}
  input wire logic [15:0] busData, // Data bus
  input wire logic [7:0] probe, // Probe clips
  output logic first_event, // First event trigger pulse
  output logic second_event, // Second event trigger pulse
  output logic limit_qualifier, // Limit mode active
  output logic traceSelect // Input mux select
);
  localparam int CYC0 = (`T_CLOCK0_NS * `CLK_MHZ + 999) / 1000;
  localparam int CYC1 = (`T_FILE1_NS * `CLK_MHZ + 999) / 1000;
  localparam int CYC2 = (`T_CLOCK1_NS * `CLK_MHZ + 999) / 1000;
  localparam logic [5:0] CNT_CLOCK0 = 6'(CYC0 - 1);
  localparam logic [5:0] CNT_FILE1 = 6'(CYC1 - 1);
  localparam logic [5:0] CNT_CLOCK1 = 6'(CYC2 - 1);
  localparam int SYNC_W = 44;

  trace_mem_if memBus ();

  trace_store_mem storeMem (
    .ref_clk(ref_clk),
    .reset(reset),
    .port(memBus)
  );

  // Pin synchronisers
  logic [SYNC_W-1:0] pinMeta;
  logic [SYNC_W-1:0] pinSync;
  logic strobeLast;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinMeta <= '0;
      pinSync <= '0;
      strobeLast <= 1'b0;
    end else begin
      pinMeta <= {transaction_strobe, busAddr, busOp, busData, probe};
      pinSync <= pinMeta;
      strobeLast <= pinSync[43];
    end
  end

  logic strobeNow;
  logic [15:0] addrNow;
  logic [2:0] opNow;
  logic [15:0] dataNow;
  logic [7:0] probeNow;
  logic leadEdge;
  logic trailEdge;
  assign strobeNow = pinSync[43];
  assign addrNow = pinSync[42:27];
  assign opNow = pinSync[26:24];
  assign dataNow = pinSync[23:8];
  assign probeNow = pinSync[7:0];
  assign leadEdge = strobeNow && !strobeLast;
  assign trailEdge = !strobeNow && strobeLast;

  // Registers
  logic [6:0] ctrl;
  logic [7:0] traceIndex;
  logic [15:0] magValue [4];
  logic [2:0] magMode [4];
  logic [7:0] bitValue [4];
  logic [7:0] bitCare [4];
  logic wideData;
  qualifier_t qualSel;
  assign wideData = ctrl[`CTRL_WIDE_BIT];
  assign qualSel = qualifier_t'(ctrl[`CTRL_QUAL_LSB +: 4]);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      limit_qualifier <= 1'b0;
    end else begin
      limit_qualifier <= ctrl[`CTRL_EVENT_LIMIT_COMMAND_BIT] | ctrl[`CTRL_BRK_LIM_BIT];
    end
  end

  // Trailing half uses the qualifier decided at the leading edge
  logic qualPass;
  logic halfKeep;
  always_comb begin
    unique case (qualSel)
      QUAL_ALL: qualPass = 1'b1;
      QUAL_FETCH: qualPass = opNow[2];
      QUAL_IO: qualPass = !opNow[0];
      QUAL_MEM: qualPass = opNow[0];
      QUAL_READ: qualPass = opNow[1];
      QUAL_WRITE: qualPass = !opNow[1];
      QUAL_IO_READ: qualPass = !opNow[0] && opNow[1];
      QUAL_IO_WRITE: qualPass = !opNow[0] && !opNow[1];
      QUAL_MEM_READ: qualPass = opNow[0] && opNow[1];
      QUAL_MEM_WRITE: qualPass = opNow[0] && !opNow[1];
      default: qualPass = 1'b1;
    endcase
  end

  // Comparator input registers
  logic [15:0] magIn;
  logic [7:0] bitIn;
  logic half;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      magIn <= '0;
      bitIn <= '0;
      half <= 1'b0;
      halfKeep <= 1'b0;
    end else if (leadEdge) begin
      magIn <= addrNow;
      bitIn <= {5'h00, opNow};
      half <= 1'b0;
      halfKeep <= qualPass;
    end else if (trailEdge) begin
      magIn <= wideData ? dataNow : {8'h00, dataNow[7:0]};
      bitIn <= probeNow;
      half <= 1'b1;
    end
  end

  // Mux select: data side between the edges
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      traceSelect <= 1'b0;
    end else if (leadEdge) begin
      traceSelect <= 1'b1;
    end else if (trailEdge) begin
      traceSelect <= 1'b0;
    end
  end

  // Trace store write path
  logic [23:0] muxOut;
  logic [7:0] writePtr;
  logic [8:0] fillCount;
  logic storeStrobeN;
  logic [23:0] storeWord;
  always_comb begin
    if (traceSelect) begin
      muxOut = {probeNow, wideData ? dataNow : {8'h00, dataNow[7:0]}};
    end else begin
      muxOut = {5'h00, opNow, addrNow};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      storeStrobeN <= 1'b1;
      storeWord <= '0;
    end else if ((leadEdge && qualPass) || (trailEdge && halfKeep)) begin
      storeStrobeN <= 1'b0;
      storeWord <= muxOut;
    end else begin
      storeStrobeN <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      writePtr <= '0;
      fillCount <= '0;
    end else if (!storeStrobeN) begin
      writePtr <= writePtr + 8'h01;
      if (fillCount != 9'(`STORE_DEPTH)) begin
        fillCount <= fillCount + 9'h001;
      end
    end
  end

  assign memBus.storeStrobeN = storeStrobeN;
  assign memBus.wrAddr = writePtr;
  assign memBus.wrData = storeWord;
  // Oldest entry is at writePtr once full
  assign memBus.rdAddr = (fillCount[8] ? writePtr : 8'h00) + traceIndex;

  // Compare sequencer
  seq_state_t seqState;
  logic [5:0] seqCount;
  logic [1:0] fileSel;
  logic [3:0] results;
  logic evalEvents;
  assign fileSel = {half, seqState == SEQ_SECOND};

  function automatic logic magHit(input logic [2:0] mode, input logic [15:0] ref16,
    input logic [15:0] in16);
    unique case (mag_mode_t'(mode))
      MAG_NONE: magHit = 1'b1;
      MAG_GE: magHit = in16 >= ref16;
      MAG_EQ: magHit = in16 == ref16;
      MAG_LE: magHit = in16 <= ref16;
      MAG_EQ8: magHit = in16[7:0] == ref16[7:0];
      default: magHit = 1'b1;
    endcase
  endfunction

  logic magOut;
  logic bitOut;
  logic fileMatch;
  assign magOut = magHit(magMode[fileSel], magValue[fileSel], magIn);
  assign bitOut = ((bitIn ^ bitValue[fileSel]) & bitCare[fileSel]) == 8'h00;
  assign fileMatch = magOut & bitOut;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seqState <= SEQ_IDLE;
      seqCount <= '0;
    end else if (leadEdge || trailEdge) begin
      seqState <= SEQ_FIRST;
      seqCount <= '0;
    end else begin
      unique case (seqState)
        SEQ_IDLE: seqCount <= '0;
        SEQ_FIRST: begin
          seqCount <= seqCount + 6'h01;
          if (seqCount == CNT_FILE1) begin
            seqState <= SEQ_SECOND;
          end
        end
        SEQ_SECOND: begin
          seqCount <= seqCount + 6'h01;
          if (seqCount == CNT_CLOCK1) begin
            seqState <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      results <= '0;
      evalEvents <= 1'b0;
    end else begin
      evalEvents <= 1'b0;
      if (leadEdge) begin
        results <= '0;
      end else if (seqState == SEQ_FIRST && seqCount == CNT_CLOCK0) begin
        results[fileSel] <= fileMatch;
      end else if (seqState == SEQ_SECOND && seqCount == CNT_CLOCK1) begin
        results[fileSel] <= fileMatch;
        evalEvents <= half;
      end
    end
  end

  // Event flip-flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_event <= 1'b0;
      second_event <= 1'b0;
    end else begin
      first_event <= evalEvents && results[0] && results[2]
        && (!limit_qualifier || results[1]);
      second_event <= evalEvents && results[1] && results[3];
    end
  end

  // Wishbone slave, one wait state
  logic access;
  logic [1:0] fileIdx;
  logic [7:0] fileOff;
  assign access = cyc_i && stb_i && !ack_o;
  assign fileIdx = adr_i[3:2];
  assign fileOff = adr_i & `OFF_FILE_MASK;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `CTRL_RESET;
      traceIndex <= '0;
      for (int i = 0; i < 4; i++) begin
        magValue[i] <= '0;
        magMode[i] <= '0;
        bitValue[i] <= '0;
        bitCare[i] <= '0;
      end
    end else if (access && we_i) begin
      if (adr_i == `OFF_CTRL && sel_i[0]) begin
        ctrl <= dat_i[6:0];
      end
      if (adr_i == `OFF_TRACE_INDEX && sel_i[0]) begin
        traceIndex <= dat_i[7:0];
      end
      if (fileOff == `OFF_MAG_BASE) begin
        if (sel_i[0]) begin
          magValue[fileIdx][7:0] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          magValue[fileIdx][15:8] <= dat_i[15:8];
        end
        if (sel_i[2]) begin
          magMode[fileIdx] <= dat_i[`MAG_MODE_LSB +: 3];
        end
      end
      if (fileOff == `OFF_BIT_BASE) begin
        if (sel_i[0]) begin
          bitValue[fileIdx] <= dat_i[7:0];
        end
        if (sel_i[1]) begin
          bitCare[fileIdx] <= dat_i[`BIT_CARE_LSB +: 8];
        end
      end
    end
  end

  logic [31:0] readWord;
  always_comb begin
    readWord = 32'h0000_0000;
    if (adr_i == `OFF_CTRL) begin
      readWord[6:0] = ctrl;
    end else if (adr_i == `OFF_STATUS) begin
      readWord[3:0] = results;
      readWord[`STAT_SEL_BIT] = traceSelect;
      readWord[`STAT_COUNT_LSB +: 9] = fillCount;
    end else if (adr_i == `OFF_TRACE_INDEX) begin
      readWord[7:0] = traceIndex;
    end else if (adr_i == `OFF_TRACE_DATA) begin
      readWord[23:0] = memBus.rdData;
    end else if (fileOff == `OFF_MAG_BASE) begin
      readWord[15:0] = magValue[fileIdx];
      readWord[`MAG_MODE_LSB +: 3] = magMode[fileIdx];
    end else if (fileOff == `OFF_BIT_BASE) begin
      readWord[7:0] = bitValue[fileIdx];
      readWord[`BIT_CARE_LSB +: 8] = bitCare[fileIdx];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dat_o <= '0;
    end else if (access) begin
      dat_o <= readWord;
    end
  end
endmodule // bus_trace_event_comparator

// ===== tb/trace_cmp_properties.sv
// Port assertions for the trace comparator
// Assumes binding onto bus_trace_event_comparator
module trace_cmp_properties (
  input wire logic ref_clk, // Clock
  input wire logic reset, // Async reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write
  input wire logic [7:0] adr_i, // Address
  input wire logic [31:0] dat_i, // Write data
  input wire logic [3:0] sel_i, // Byte enables
  input wire logic [31:0] dat_o, // Read data
  input wire logic ack_o, // Acknowledge
  input wire logic transaction_strobe, // Bus strobe
  input wire logic first_event, // First trigger
  input wire logic second_event, // Second trigger
  input wire logic limit_qualifier, // Limit mode
  input wire logic traceSelect // Mux select
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic selD;
  logic [7:0] sinceFall;
  wire logic req = cyc_i && stb_i && !ack_o;
  // Cycles since the select fell
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      selD <= 1'b0;
      sinceFall <= 8'hFF;
    end else begin
      selD <= traceSelect;
      if (selD && !traceSelect) sinceFall <= 8'h01;
      else if (sinceFall != 8'hFF) sinceFall <= sinceFall + 8'h01;
    end
  end
  a_ack_next: assert property (req |=> ack_o)
    else $error("ack missing");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (req && !we_i && adr_i == 8'h40 |=> ack_o && dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_select_rise: assert property ($rose(transaction_strobe) |-> ##[1:6] $rose(traceSelect))
    else $error("select late after rise");
  a_select_fall: assert property ($fell(transaction_strobe) |-> ##[1:6] $fell(traceSelect))
    else $error("select late after fall");
  a_first_timing: assert property (first_event |-> sinceFall >= 8'h28 && sinceFall <= 8'h2D)
    else $error("first event off time");
  a_second_timing: assert property (second_event |-> sinceFall >= 8'h28 && sinceFall <= 8'h2D)
    else $error("second event off time");
  a_limit_cmd: assert property (req && we_i && adr_i == 8'h00 && sel_i[0] |=> ##1
    limit_qualifier == ($past(dat_i[4], 2) | $past(dat_i[5], 2)))
    else $error("limit qualifier wrong");
  c_first: cover property (first_event);
  c_second: cover property (second_event);
  c_limited: cover property (limit_qualifier && first_event);
endmodule // trace_cmp_properties

bind bus_trace_event_comparator trace_cmp_properties chk_u (.ref_clk(ref_clk), .reset(reset),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .dat_o(dat_o), .ack_o(ack_o), .transaction_strobe(transaction_strobe),
  .first_event(first_event), .second_event(second_event),
  .limit_qualifier(limit_qualifier), .traceSelect(traceSelect));

// ===== tb/bus_side_model.sv
// Emulator bus side: one strobe per transaction, pins per half
// Assumes the bench calls transact one at a time
module bus_side_model (
  output logic transaction_strobe, // Bus strobe
  output logic [15:0] busAddr, // Address pins
  output logic [2:0] busOp, // Bus-op pins
  output logic [15:0] busData, // Data pins
  output logic [7:0] probe // Probe pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic linkClk;
  initial begin
    linkClk = 1'b0;
    #3;
    forever #16 linkClk = ~linkClk;
  end
  initial begin
    transaction_strobe = 1'b0;
    busAddr = 16'h0000;
    busOp = 3'h0;
    busData = 16'h0000;
    probe = 8'h00;
  end
  // Halves of 6 and 8 link cycles; released pins inverted
  task automatic transact(input logic [15:0] a, input logic [2:0] op, input logic [15:0] d,
    input logic [7:0] pr);
    @(posedge linkClk);
    busAddr <= a;
    busOp <= op;
    @(posedge linkClk);
    transaction_strobe <= 1'b1;
    @(posedge linkClk);
    busData <= d;
    probe <= pr;
    @(posedge linkClk);
    busAddr <= ~a;
    busOp <= ~op;
    repeat (4) @(posedge linkClk);
    transaction_strobe <= 1'b0;
    @(posedge linkClk);
    busData <= ~d;
    probe <= ~pr;
    repeat (7) @(posedge linkClk);
  endtask
endmodule // bus_side_model

// ===== tb/bus_trace_event_comparator_bench.sv
// Self-checking bench for the trace comparator
// Assumes the bus side model and the bound checker
module bus_trace_event_comparator_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, cyc, stb, we, ack, strobe, firstEvt, secondEvt, limitQual, traceSel;
  logic [7:0] adr, probe;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [15:0] busAddr, busData;
  logic [2:0] busOp;
  int n_fail = 0, cmp_count = 0, firstCount = 0, secondCount = 0, cycles = 0;

  bus_trace_event_comparator dut_u (.ref_clk(ref_clk), .reset(reset), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat),
    .ack_o(ack), .transaction_strobe(strobe), .busAddr(busAddr), .busOp(busOp),
    .busData(busData), .probe(probe), .first_event(firstEvt), .second_event(secondEvt),
    .limit_qualifier(limitQual), .traceSelect(traceSel));
  bus_side_model model_u (.transaction_strobe(strobe), .busAddr(busAddr), .busOp(busOp),
    .busData(busData), .probe(probe));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (firstEvt === 1'b1) firstCount++;
    if (secondEvt === 1'b1) secondCount++;
    if (cycles == 60000) begin
      n_fail++;
      give_verdict;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n == 20) check("ack wait", 32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic clear_files;
    for (int i = 0; i < 8; i++) wr(8'h10 + 8'(4 * i), 32'h0);
  endtask

  task automatic run_case(input logic [15:0] a, input logic [2:0] op, input logic [15:0] d,
    input logic [7:0] pr, input logic [3:0] expR, input logic ef, input logic es);
    int f0, s0;
    logic [31:0] q;
    f0 = firstCount;
    s0 = secondCount;
    model_u.transact(a, op, d, pr);
    wb(1'b0, 8'h04, 32'h0, q);
    check("results", {28'h0, q[3:0]}, {28'h0, expR});
    check("select idle", {31'h0, q[4]}, 32'h0);
    check("first event", 32'(firstCount - f0), {31'h0, ef});
    check("second event", 32'(secondCount - s0), {31'h0, es});
  endtask

  function automatic logic qpass(input logic [3:0] q, input logic [2:0] op);
    case (q)
      4'h1: return op[2];
      4'h2: return !op[0];
      4'h3: return op[0];
      4'h4: return op[1];
      4'h5: return !op[1];
      4'h6: return !op[0] && op[1];
      4'h7: return !op[0] && !op[1];
      4'h8: return op[0] && op[1];
      4'h9: return op[0] && !op[1];
      default: return 1'b1;
    endcase
  endfunction

  task automatic s_registers;
    logic [7:0] regs [5] = '{8'h00, 8'h04, 8'h10, 8'h2C, 8'h40};
    logic [31:0] q;
    wr(8'h40, 32'hFFFFFFFF);
    wr(8'h04, 32'hFFFFFFFF);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0, q);
      check("reset register", q, 32'h0);
    end
  endtask

  task automatic s_events;
    clear_files;
    wr(8'h00, 32'h40);
    wr(8'h10, 32'h0002_1234);
    wr(8'h20, 32'h0000_0703);
    wr(8'h18, 32'h0002_00AB);
    wr(8'h28, 32'h0000_FF5A);
    run_case(16'h1234, 3'b011, 16'h00AB, 8'h5A, 4'hF, 1'b1, 1'b1);
    run_case(16'h1235, 3'b011, 16'h00AB, 8'h5A, 4'hE, 1'b0, 1'b1);
    run_case(16'h1234, 3'b001, 16'h00AB, 8'h5A, 4'hE, 1'b0, 1'b1);
    run_case(16'h1234, 3'b011, 16'h00AB, 8'h5B, 4'hB, 1'b0, 1'b1);
    run_case(16'h1234, 3'b011, 16'h01AB, 8'h5A, 4'hB, 1'b0, 1'b1);
    wr(8'h00, 32'h0);
    run_case(16'h1234, 3'b011, 16'h77AB, 8'h5A, 4'hF, 1'b1, 1'b1);
  endtask

  task automatic s_modes;
    logic [39:0] tbl [8] = '{40'h11_1000_1000, 40'h01_1000_0FFF, 40'h13_1000_1000,
      40'h03_1000_1001, 40'h14_00AB_12AB, 40'h04_00AB_12AC, 40'h12_5555_5555,
      40'h15_1234_0000};
    clear_files;
    wr(8'h00, 32'h40);
    foreach (tbl[i]) begin
      wr(8'h14, {13'h0, tbl[i][34:32], tbl[i][31:16]});
      run_case(tbl[i][15:0], 3'b011, 16'h0, 8'h0, {2'b11, tbl[i][36], 1'b1}, 1'b1,
        tbl[i][36]);
    end
  endtask

  task automatic s_limit;
    logic [31:0] ctl [3] = '{32'h50, 32'h60, 32'h40};
    clear_files;
    wr(8'h14, 32'h0002_0001);
    foreach (ctl[i]) begin
      wr(8'h00, ctl[i]);
      @(posedge ref_clk);
      check("limit qualifier", {31'h0, limitQual}, {31'h0, i < 2});
      run_case(16'h1234, 3'b011, 16'h0, 8'h0, 4'hD, i == 2, 1'b0);
    end
    wr(8'h00, 32'h50);
    run_case(16'h0001, 3'b011, 16'h0, 8'h0, 4'hF, 1'b1, 1'b1);
  endtask

  task automatic s_qualify;
    logic [2:0] ops [4] = '{3'b111, 3'b000, 3'b010, 3'b001};
    logic [31:0] q0, q1;
    clear_files;
    for (int q = 0; q < 11; q++) begin
      wr(8'h00, 32'h40 | 32'(q));
      foreach (ops[o]) begin
        wb(1'b0, 8'h04, 32'h0, q0);
        model_u.transact(16'h0, ops[o], 16'h0, 8'h0);
        wb(1'b0, 8'h04, 32'h0, q1);
        check("fill step", 32'(q1[24:16] - q0[24:16]), qpass(4'(q), ops[o]) ? 2 : 0);
      end
    end
  endtask

  task automatic s_fill;
    logic [31:0] q;
    logic [7:0] idx [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
    logic [23:0] exp [4] = '{24'h03_2002, 24'h02_C002, 24'h03_2081, 24'h81_C081};
    wr(8'h00, 32'h40);
    for (int i = 0; i < 130; i++) begin
      model_u.transact(16'h2000 + 16'(i), 3'b011, 16'hC000 + 16'(i), 8'(i));
    end
    wb(1'b0, 8'h04, 32'h0, q);
    check("fill count", {23'h0, q[24:16]}, 32'h100);
    foreach (idx[i]) begin
      wr(8'h08, {24'h0, idx[i]});
      repeat (2) @(posedge ref_clk);
      wb(1'b0, 8'h0C, 32'h0, q);
      check("trace entry", {8'h0, q[23:0]}, {8'h0, exp[i]});
    end
  endtask

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    s_registers;
    s_events;
    s_modes;
    s_limit;
    s_qualify;
    s_fill;
    give_verdict;
  end
endmodule // bus_trace_event_comparator_bench
